/* File: bench/hsi_checker.sv */
// Bus wire assertions for the sensor target and controller pair.
`default_nettype none
module hsi_checker
    import hsi_pkg::*;
(
    // Clock, reset and target state
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CONV_BUSY_I,
    input wire logic [CFG_W-1:0] CFG_O,
    // Bus wires
    input wire logic scl_dev_oe_n,
    input wire logic sda_dev_oe_n,
    input wire logic int_oe_n,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic act_r;
    logic [8:0] low_r;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // Tracks a frame from start to stop and the length of an interrupt pulse.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            act_r <= 1'b0;
            low_r <= 9'h0;
        end else begin
            if (scl && $changed(sda))
                act_r <= !sda;
            low_r <= int_oe_n ? 9'h0 : low_r + 9'h1;
        end
    end
    property p_sf; $fell(scl_dev_oe_n) |-> CFG_O[1:0] == 2'b01 && CONV_BUSY_I; endproperty
    a_sf: assert property (p_sf) else $error("stretch out of place");
    property p_nm; CFG_O[1:0] != 2'b01 |-> scl_dev_oe_n; endproperty
    a_nm: assert property (p_nm) else $error("stretch in wrong mode");
    property p_hb; !scl_dev_oe_n |-> CONV_BUSY_I || $past(CONV_BUSY_I, 2); endproperty
    a_hb: assert property (p_hb) else $error("stretch after conversion");
    property p_bk; $fell(int_oe_n) && CFG_O[1:0] == 2'b00 |-> !$past(act_r, 3); endproperty
    a_bk: assert property (p_bk) else $error("pulse inside frame");
    property p_io; $fell(int_oe_n) |-> CFG_O[1:0] != 2'b01; endproperty
    a_io: assert property (p_io) else $error("pulse in stretch mode");
    property p_pm; low_r <= INT_PULSE_CYC; endproperty
    a_pm: assert property (p_pm) else $error("pulse too long");
    property p_pf; $rose(int_oe_n) && CFG_O[1] |-> low_r == INT_PULSE_CYC; endproperty
    a_pf: assert property (p_pf) else $error("pulse cut");
    property p_dc; $changed(sda_dev_oe_n) |-> !scl; endproperty
    a_dc: assert property (p_dc) else $error("data moved with clock high");
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Bench: controller drives the sensor target over a shared bus.
`default_nettype none
module testbench
    import hsi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, bsy = 0, dn = 0, sup = 1, ev = 0, wr = 0, rd = 0;
    logic str = 0, isn = 0, rsn = 0, irq, srst;
    logic [7:0] meas = 8'h0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, rdat, v;
    logic [CFG_W-1:0] cfg;
    logic [7:0] q[$];
    int n_fail = 0, n_checks = 0, seed = 32'hda78, frame_counter = 0, sm = 0;
    hsi_if bus();
    hsi_dev hsi_dev_i(.CLK_I(clk), .RST_I(rst), .BUS(bus.dev), .CONV_BUSY_I(bsy),
        .CONV_DONE_I(dn), .SUPPLY_OK_I(sup), .MEAS_I(meas), .EVENT_I(ev),
        .SOFT_RST_O(srst), .CFG_O(cfg));
    hsi_host #(.QDIV(8), .RST_WAIT(50)) hsi_host_i(.CLK_I(clk), .RST_I(rst),
        .BUS(bus.host), .ADDR_I(adr), .WDATA_I(wd), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdat), .IRQ_O(irq));
    hsi_checker hsi_checker_i(.CLK_I(clk), .RST_I(rst), .CONV_BUSY_I(bsy), .CFG_O(cfg),
        .scl_dev_oe_n(bus.scl_dev_oe_n), .sda_dev_oe_n(bus.sda_dev_oe_n),
        .int_oe_n(bus.int_oe_n), .scl(bus.scl), .sda(bus.sda));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (bus.scl_dev_oe_n === 1'b0) str <= 1;
        if (bus.int_n === 1'b0) isn <= 1;
        if (srst === 1'b1) rsn <= 1;
    end
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task tally_and_finish;
        if (n_fail == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task swr(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task srd(logic [3:0] a);
        @(posedge clk);
        adr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 v = rdat;
    endtask
    task cmd(logic [2:0] op, logic [7:0] b = 8'h0, logic ak = 1'b0);
        int i;
        swr(HR_CMD, {15'h0, ak, b, 5'h0, op});
        i = 0;
        do begin
            srd(HR_STAT);
            i++;
        end while (v[0] !== 1'b0 && i < 4000);
        if (v[0] !== 1'b0) begin
            n_fail++;
            tally_and_finish;
        end
    endtask
    task wcfg(logic [2:0] c);
        cmd(OP_START);
        cmd(OP_WRITE, {DEV_ADDR_DEF, 1'b0});
        chk("ack", 0, v[1]);
        cmd(OP_WRITE, CFG_ADR);
        cmd(OP_WRITE, {5'h0, c});
        cmd(OP_STOP);
        chk("cfg", c, cfg);
    endtask
    task brst;
        rsn = 0;
        cmd(OP_RESET);
        chk("soft reset", 1, rsn);
        chk("cfg default", CFG_RST, cfg);
        frame_counter = 0;
    endtask
    task pulse_ev;
        @(posedge clk) ev <= 1;
        @(posedge clk) ev <= 0;
    endtask
    task conv_b;
        sm = $random(seed) & 1;
        @(posedge clk);
        sup <= sm[0];
        meas <= $random(seed);
        bsy <= 1;
    endtask
    task conv_e(int n);
        repeat (n) @(posedge clk);
        bsy <= 0;
        dn <= 1;
        @(posedge clk);
        dn <= 0;
        frame_counter = (frame_counter + 1) % 4;
        q.push_back({sm[0], 1'b1, 4'h0, frame_counter[1:0]});
    endtask
    task rd_st(logic pr, logic st);
        cmd(OP_START);
        fork
            cmd(OP_WRITE, {DEV_ADDR_DEF, 1'b1});
            if (st) conv_e(600);
        join
        if (!pr) cmd(OP_WRITE, STAT_ADR);
        cmd(OP_READ, 8'h0, 1'b1);
        chk("status", q.pop_front(), v[15:8]);
        cmd(OP_READ, 8'h0, 1'b1);
        chk("after nack", 8'hff, v[15:8]);
        cmd(OP_STOP);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        brst;
        for (int m = 0; m < 4; m++) begin
            wcfg(m[2:0]);
            swr(HR_MASK, m == 3 ? 32'h0 : 32'h4);
            srd(HR_IRQ);
            isn = 0;
            cmd(OP_START);
            cmd(OP_WRITE, 8'h40);
            pulse_ev;
            repeat (300) @(posedge clk);
            chk("int in frame", m >= 2, isn);
            cmd(OP_STOP);
            repeat (300) @(posedge clk);
            chk("int after stop", m != 1, isn);
            chk("irq line", !m[0], irq);
            srd(HR_IRQ);
            chk("irq status", m != 1, v[2]);
            repeat (2) @(posedge clk);
            chk("irq clear", 0, irq);
        end
        wcfg(3'h4);
        cmd(OP_START);
        isn = 0;
        pulse_ev;
        repeat (400) @(posedge clk);
        chk("int blocked", 0, isn);
        brst;
        for (int k = 0; k < 5; k++) begin
            conv_b;
            conv_e(20 + ($random(seed) & 63));
            rd_st(1'b0, 1'b0);
        end
        for (int p = 0; p < 2; p++) begin
            wcfg({p[0], 2'b01});
            conv_b;
            str = 0;
            rd_st(p[0], 1'b1);
            chk("stretched", 1, str);
        end
        conv_b;
        str = 0;
        wcfg(3'h1);
        chk("write stretched", 0, str);
        conv_e(5);
        rd_st(1'b0, 1'b0);
        tally_and_finish;
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        tally_and_finish;
    end
endmodule
`default_nettype wire

/* File: src/hsi_cond.sv */
// Synchroniser and edge, start and stop detector for the two bus wires.
`default_nettype none

module hsi_cond (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Raw wires
    input wire logic scl_i,
    input wire logic sda_i,
    // Synchronised levels and events
    output logic scl_o,
    output logic sda_o,
    output logic rise_o,
    output logic fall_o,
    output logic start_o,
    output logic stop_o
);

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
    } hsi_cond_t;

    hsi_cond_t r;
    hsi_cond_t n;

    always_comb begin
        n = r;
        n.s1 = {scl_i, sda_i};
        n.s2 = r.s1;
        n.s3 = r.s2;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3};
        end else begin
            r <= n;
        end
    end

    assign scl_o = r.s2[1];
    assign sda_o = r.s2[0];
    assign rise_o = r.s2[1] & ~r.s3[1];
    assign fall_o = ~r.s2[1] & r.s3[1];
    assign start_o = r.s2[1] & r.s3[1] & ~r.s2[0] & r.s3[0];
    assign stop_o = r.s2[1] & r.s3[1] & r.s2[0] & ~r.s3[0];

endmodule

`default_nettype wire

/* File: src/hsi_dev.sv */
// Sensor bus target: collision avoidance, clock stretching, bus reset, flags.
//
// The register addresses and the strobed register port are this design's own decisions.
`default_nettype none

module hsi_dev
    import hsi_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // Bus wires
    hsi_if.dev BUS,
    // Conversion engine
    input wire logic CONV_BUSY_I,
    input wire logic CONV_DONE_I,
    input wire logic SUPPLY_OK_I,
    input wire logic [7:0] MEAS_I,
    // Interrupt request from the sensing logic
    input wire logic EVENT_I,
    // Status towards the sensing logic
    output logic SOFT_RST_O,
    output logic [CFG_W-1:0] CFG_O
);

    typedef enum logic [3:0] {
        D_IDLE, D_ADDR, D_AACK, D_WBYTE, D_WACK, D_RBYTE, D_RACK, D_RACK2, D_NACKH
    } hsi_dst_t;

    typedef struct packed {
        hsi_dst_t st;
        logic [3:0] bcnt;
        logic [7:0] sh;
        logic rd;
        logic first;
        logic [7:0] ptr;
        logic [CFG_W-1:0] cfg;
        logic [FRM_W-1:0] frame_counter;
        logic done_f;
        logic sup_f;
        logic cbusy;
        logic busy;
        logic pend;
        logic [7:0] icnt;
        logic int_n;
        logic sda_n;
        logic scl_n;
        logic [3:0] fbits;
        logic [7:0] fbyte;
        logic [1:0] rseq;
        logic srst;
    } hsi_dev_state_t;

    localparam hsi_dev_state_t D_RST = '{
        st: D_IDLE, cfg: CFG_RST, int_n: 1'b1, sda_n: 1'b1, scl_n: 1'b1, default: '0
    };

    hsi_dev_state_t r;
    hsi_dev_state_t n;

    logic scl_s;
    logic sda_s;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic avoid;
    logic stretch;
    logic int_en;
    logic ld;

    hsi_cond u_cond (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .scl_i(BUS.scl),
        .sda_i(BUS.sda),
        .scl_o(scl_s),
        .sda_o(sda_s),
        .rise_o(rise),
        .fall_o(fall),
        .start_o(start),
        .stop_o(stop)
    );

    // Byte returned for a register pointer; beyond the map the line stays high.
    function automatic logic [7:0] rd_byte(input hsi_dev_state_t s, input logic [7:0] m);
        logic [7:0] b;
        b = m;
        if (s.ptr == STAT_ADR) begin
            b = {s.sup_f, s.done_f, 4'h0, s.frame_counter};
        end else if (s.ptr == CFG_ADR) begin
            b = {5'h00, s.cfg};
        end else if (s.ptr > PTR_MASK) begin
            b = RST_BYTE_HI;
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        n = r;
        n.srst = 1'b0;
        ld = 1'b0;
        // Both bits set falls back to the plain behaviour of 1/0.
        avoid = ~r.cfg[CFG_CA] & ~r.cfg[CFG_INT];
        stretch = ~r.cfg[CFG_CA] & r.cfg[CFG_INT];
        int_en = r.cfg[CFG_CA] | ~r.cfg[CFG_INT];

        // Conversion monitor.
        n.cbusy = CONV_BUSY_I;
        if (CONV_BUSY_I & ~r.cbusy) begin
            n.sup_f = 1'b1;
            n.done_f = 1'b0;
        end
        if (CONV_BUSY_I & ~SUPPLY_OK_I) begin
            n.sup_f = 1'b0;
        end
        if (CONV_DONE_I) begin
            n.frame_counter = r.frame_counter + 1'b1;
            n.done_f = 1'b1;
        end

        // Bus occupancy is tracked for every transfer, addressed or not.
        if (start) begin
            n.busy = 1'b1;
        end else if (stop) begin
            n.busy = 1'b0;
        end

        // Interrupt pulse generation.
        if (r.icnt != 8'h00) begin
            n.icnt = r.icnt - 8'h01;
            if (r.icnt == 8'h01) begin
                n.int_n = 1'b1;
            end
            if (avoid & start) begin
                n.icnt = 8'h00;
                n.int_n = 1'b1;
            end
        end else if (r.pend & ~(avoid & (r.busy | start))) begin
            n.pend = 1'b0;
            n.int_n = 1'b0;
            n.icnt = 8'(INT_PULSE_CYC);
        end
        if (EVENT_I & int_en) begin
            n.pend = 1'b1;
        end

        // Frame watcher for the bus reset sequence.
        if (start) begin
            n.fbits = 4'h0;
        end else if (rise) begin
            if (r.fbits != 4'hf) begin
                n.fbits = r.fbits + 4'h1;
            end
            if (r.fbits < BYTE_BITS) begin
                n.fbyte = {r.fbyte[6:0], sda_s};
            end
        end

        // Protocol engine.
        unique case (r.st)
            D_IDLE, D_NACKH: begin
            end
            D_ADDR: begin
                if (rise) begin
                    n.sh = {r.sh[6:0], sda_s};
                    n.bcnt = r.bcnt + 4'h1;
                end else if (fall & (r.bcnt == BYTE_BITS)) begin
                    if (r.sh[7:1] == DEV_ADDR) begin
                        n.st = D_AACK;
                        n.rd = r.sh[0];
                        n.sda_n = 1'b0;
                        n.scl_n = ~(r.sh[0] & stretch & CONV_BUSY_I);
                    end else begin
                        n.st = D_IDLE;
                    end
                end
            end
            D_AACK: begin
                if (~r.scl_n & ~CONV_BUSY_I) begin
                    n.scl_n = 1'b1;
                end
                if (fall) begin
                    n.sda_n = 1'b1;
                    n.bcnt = 4'h0;
                    n.first = 1'b1;
                    if (r.rd & r.cfg[CFG_PR]) begin
                        n.ptr = STAT_ADR;
                        ld = 1'b1;
                    end else begin
                        n.st = D_WBYTE;
                    end
                end
            end
            D_WBYTE: begin
                if (rise) begin
                    n.sh = {r.sh[6:0], sda_s};
                    n.bcnt = r.bcnt + 4'h1;
                end else if (fall & (r.bcnt == BYTE_BITS)) begin
                    n.st = D_WACK;
                    n.sda_n = 1'b0;
                    if (r.first) begin
                        n.first = 1'b0;
                        n.ptr = r.sh & PTR_MASK;
                    end else begin
                        if (r.ptr == CFG_ADR) begin
                            n.cfg = r.sh[CFG_W-1:0];
                        end
                        n.ptr = r.ptr + 8'h01;
                    end
                end
            end
            D_WACK: begin
                if (fall) begin
                    n.sda_n = 1'b1;
                    n.bcnt = 4'h0;
                    if (r.rd) begin
                        ld = 1'b1;
                    end else begin
                        n.st = D_WBYTE;
                    end
                end
            end
            D_RBYTE: begin
                if (fall) begin
                    if (r.bcnt == BYTE_BITS) begin
                        n.st = D_RACK;
                        n.sda_n = 1'b1;
                    end else begin
                        n.sh = {r.sh[6:0], 1'b0};
                        n.sda_n = r.sh[6];
                        n.bcnt = r.bcnt + 4'h1;
                    end
                end
            end
            D_RACK: begin
                if (rise) begin
                    n.st = sda_s ? D_NACKH : D_RACK2;
                end
            end
            D_RACK2: begin
                if (fall) begin
                    n.ptr = r.ptr + 8'h01;
                    ld = 1'b1;
                end
            end
            default: begin
                n.st = D_IDLE;
            end
        endcase

        if (ld) begin
            n.st = D_RBYTE;
            n.sh = rd_byte(n, MEAS_I);
            n.sda_n = n.sh[7];
            n.bcnt = 4'h1;
        end

        if (start) begin
            n.st = D_ADDR;
            n.bcnt = 4'h0;
            n.sda_n = 1'b1;
            n.scl_n = 1'b1;
        end else if (stop) begin
            n.st = D_IDLE;
            n.sda_n = 1'b1;
            n.scl_n = 1'b1;
            // The clock rise that comes just before the stop is counted as well.
            if ((r.fbits == BYTE_ACK_BITS) | (r.fbits == BYTE_ACK_BITS + 4'h1)) begin
                if (r.fbyte == RST_BYTE_HI) begin
                    n.rseq = ((r.rseq == 2'h1) | (r.rseq == 2'h2)) ? 2'h2 : 2'h1;
                end else if ((r.fbyte == RST_BYTE_LO) & (r.rseq == 2'h2)) begin
                    n.rseq = 2'h3;
                end else if ((r.fbyte == RST_BYTE_LO) & (r.rseq == 2'h3)) begin
                    n = D_RST;
                    n.srst = 1'b1;
                end else begin
                    n.rseq = 2'h0;
                end
            end else begin
                n.rseq = 2'h0;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            r <= D_RST;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign BUS.scl_dev_oe_n = r.scl_n;
    assign BUS.sda_dev_oe_n = r.sda_n;
    assign BUS.int_oe_n = r.int_n;
    assign SOFT_RST_O = r.srst;
    assign CFG_O = r.cfg;

endmodule

`default_nettype wire

/* File: src/hsi_host.sv */
// Bus controller: byte engine, bus reset sequence and software registers.
`default_nettype none

module hsi_host
    import hsi_pkg::*;
#(
    parameter int QDIV = 50,
    parameter int RST_WAIT = RST_WAIT_CYC
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // Bus wires
    hsi_if.host BUS,
    // Software port
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    output logic IRQ_O
);

    typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_WAIT} hsi_hst_t;

    typedef struct packed {
        hsi_hst_t st;
        hsi_op_t op;
        logic [1:0] q;
        logic [15:0] div;
        logic [3:0] bcnt;
        logic [8:0] tx;
        logic [8:0] rx;
        logic rs;
        logic [1:0] rf;
        logic [15:0] wcnt;
        logic scl_n;
        logic sda_n;
        logic [IRQ_W-1:0] irq;
        logic [IRQ_W-1:0] mask;
        logic [31:0] rdata;
        logic irq_o;
        logic i1;
        logic i2;
        logic i3;
    } hsi_host_state_t;

    hsi_host_state_t r;
    hsi_host_state_t n;

    logic scl_s;
    logic sda_s;
    logic tick;
    logic adv;
    logic fin;

    hsi_cond u_cond (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .scl_i(BUS.scl),
        .sda_i(BUS.sda),
        .scl_o(scl_s),
        .sda_o(sda_s),
        .rise_o(),
        .fall_o(),
        .start_o(),
        .stop_o()
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        n = r;
        fin = 1'b0;
        n.i1 = BUS.int_n;
        n.i2 = r.i1;
        n.i3 = r.i2;
        if (RD_I & (ADDR_I == HR_IRQ)) begin
            n.irq = '0;
        end
        tick = (r.div == 16'h0000);
        n.div = tick ? 16'(QDIV - 1) : r.div - 16'h0001;
        // A target holding the clock low stalls the high phase.
        adv = tick & ~((r.q == 2'h2) & ~scl_s & ((r.st == H_BIT) | (r.st == H_STOP)));
        unique case (r.st)
            H_IDLE: begin
            end
            H_START: begin
                if (adv) begin
                    unique case (r.q)
                        2'h0: n.sda_n = 1'b1;
                        2'h1: n.scl_n = 1'b1;
                        2'h2: n.sda_n = 1'b0;
                        2'h3: begin
                            n.scl_n = 1'b0;
                            fin = 1'b1;
                        end
                    endcase
                end
            end
            H_BIT: begin
                if (adv) begin
                    unique case (r.q)
                        2'h0: n.sda_n = r.tx[8];
                        2'h1: n.scl_n = 1'b1;
                        2'h2: n.rx = {r.rx[7:0], sda_s};
                        2'h3: begin
                            n.scl_n = 1'b0;
                            n.tx = {r.tx[7:0], 1'b1};
                            n.bcnt = r.bcnt + 4'h1;
                            fin = (r.bcnt == BYTE_BITS);
                        end
                    endcase
                end
            end
            H_STOP: begin
                if (adv) begin
                    unique case (r.q)
                        2'h0: n.sda_n = 1'b0;
                        2'h1: n.scl_n = 1'b1;
                        2'h2: n.sda_n = 1'b1;
                        2'h3: fin = 1'b1;
                    endcase
                end
            end
            H_WAIT: begin
                n.wcnt = r.wcnt - 16'h0001;
                if (r.wcnt == 16'h0000) begin
                    n.st = H_IDLE;
                    n.rs = 1'b0;
                    n.irq[IRQ_DONE] = 1'b1;
                end
            end
            default: n.st = H_IDLE;
        endcase
        if (adv & (r.st != H_IDLE) & (r.st != H_WAIT)) begin
            n.q = r.q + 2'h1;
        end

        if (fin & r.rs) begin
            n.bcnt = 4'h0;
            if (r.st == H_START) begin
                n.st = H_BIT;
                n.tx = {(r.rf < 2'h2) ? RST_BYTE_HI : RST_BYTE_LO, 1'b1};
            end else if (r.st == H_BIT) begin
                n.st = H_STOP;
            end else if (r.rf == 2'h3) begin
                n.st = H_WAIT;
                n.wcnt = 16'(RST_WAIT - 1);
            end else begin
                n.rf = r.rf + 2'h1;
                n.st = H_START;
            end
        end else if (fin) begin
            n.st = H_IDLE;
            n.irq[IRQ_DONE] = 1'b1;
            if ((r.op == OP_WRITE) & n.rx[0]) begin
                n.irq[IRQ_NACK] = 1'b1;
            end
        end

        if (r.i3 & ~r.i2) begin
            n.irq[IRQ_DEVINT] = 1'b1;
        end

        if (WR_I & (ADDR_I == HR_MASK)) begin
            n.mask = WDATA_I[IRQ_W-1:0];
        end
        if (WR_I & (ADDR_I == HR_CMD) & (r.st == H_IDLE)) begin
            n.op = hsi_op_t'(WDATA_I[2:0]);
            n.q = 2'h0;
            n.bcnt = 4'h0;
            unique case (hsi_op_t'(WDATA_I[2:0]))
                OP_START: n.st = H_START;
                OP_STOP: n.st = H_STOP;
                OP_WRITE: begin
                    n.st = H_BIT;
                    n.tx = {WDATA_I[CMD_DAT_LSB+:8], 1'b1};
                end
                OP_READ: begin
                    n.st = H_BIT;
                    n.tx = {RST_BYTE_HI, WDATA_I[CMD_ACK_BIT]};
                end
                OP_RESET: begin
                    n.st = H_START;
                    n.rs = 1'b1;
                    n.rf = 2'h0;
                end
                default: n.st = H_IDLE;
            endcase
        end

        n.rdata = 32'h0000_0000;
        if (RD_I) begin
            unique case (ADDR_I)
                HR_STAT: n.rdata = {16'h0000, r.rx[8:1], 6'h00, r.rx[0], r.st != H_IDLE};
                HR_IRQ: n.rdata = {29'h0, r.irq};
                HR_MASK: n.rdata = {29'h0, r.mask};
                default: n.rdata = 32'h0000_0000;
            endcase
        end
        n.irq_o = |(n.irq & n.mask);
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            r <= '{st: H_IDLE, op: OP_NONE, scl_n: 1'b1, sda_n: 1'b1,
                   i1: 1'b1, i2: 1'b1, i3: 1'b1, default: '0};
        end else begin
            r <= n;
        end
    end

    assign BUS.scl_host_oe_n = r.scl_n;
    assign BUS.sda_host_oe_n = r.sda_n;
    assign RDATA_O = r.rdata;
    assign IRQ_O = r.irq_o;

endmodule

`default_nettype wire

/* File: src/hsi_if.sv */
// Open-drain bus wires joining the sensor target and the bus controller.
`default_nettype none

interface hsi_if;
    logic scl_dev_oe_n;
    logic sda_dev_oe_n;
    logic int_oe_n;
    logic scl_host_oe_n;
    logic sda_host_oe_n;
    logic scl;
    logic sda;
    logic int_n;

    // Pulled-up wires: low whenever any party drives them.
    assign scl = scl_dev_oe_n & scl_host_oe_n;
    assign sda = sda_dev_oe_n & sda_host_oe_n;
    assign int_n = int_oe_n;

    modport dev (output scl_dev_oe_n, sda_dev_oe_n, int_oe_n, input scl, sda);
    modport host (output scl_host_oe_n, sda_host_oe_n, input scl, sda, int_n);
endinterface

`default_nettype wire

/* File: src/hsi_pkg.sv */
// Shared constants and types for the hall sensor bus target and its controller.
`default_nettype none

package hsi_pkg;

    localparam int CLK_MHZ = 200;

    // Bus address of the sensor target, upper seven bits of the address byte.
    localparam logic [6:0] DEV_ADDR_DEF = 7'h35;

    // Register pointers inside the target.
    localparam logic [7:0] STAT_ADR = 8'h00;
    localparam logic [7:0] CFG_ADR = 8'h11;
    localparam logic [7:0] PTR_MASK = 8'h1f;

    // Configuration byte layout and its value after any reset.
    localparam int CFG_INT = 0;
    localparam int CFG_CA = 1;
    localparam int CFG_PR = 2;
    localparam int CFG_W = 3;
    localparam logic [CFG_W-1:0] CFG_RST = 3'h0;

    localparam int FRM_W = 2;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BYTE_ACK_BITS = 4'h9;

    // Bus reset sequence bytes and the settle time after it.
    localparam logic [7:0] RST_BYTE_HI = 8'hff;
    localparam logic [7:0] RST_BYTE_LO = 8'h00;
    localparam int RST_WAIT_US = 30;
    localparam int RST_WAIT_CYC = RST_WAIT_US * CLK_MHZ;

    // Length of one interrupt pulse on the open interrupt line.
    localparam int INT_PULSE_NS = 1000;
    localparam int INT_PULSE_CYC = (INT_PULSE_NS * CLK_MHZ + 999) / 1000;

    // Controller register offsets.
    localparam logic [3:0] HR_CMD = 4'h0;
    localparam logic [3:0] HR_STAT = 4'h4;
    localparam logic [3:0] HR_IRQ = 4'h8;
    localparam logic [3:0] HR_MASK = 4'hc;

    // Controller command word fields.
    localparam int CMD_DAT_LSB = 8;
    localparam int CMD_ACK_BIT = 16;

    // Controller interrupt status bits.
    localparam int IRQ_DONE = 0;
    localparam int IRQ_NACK = 1;
    localparam int IRQ_DEVINT = 2;
    localparam int IRQ_W = 3;

    typedef enum logic [2:0] {OP_NONE, OP_START, OP_STOP, OP_WRITE, OP_READ, OP_RESET} hsi_op_t;

endpackage

`default_nettype wire
